// ===== hw/channel_pair_pkg.sv
// constants for the channel pair control bank
// assumes an apb slave with 32-bit words, one word per register
package channel_pair_pkg;

  localparam int          PAIR_COUNT  = 10;
  localparam int          CHAN_COUNT  = 20;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_129_130 = 12'h0c8;
  localparam logic [11:0] IDX_131_132 = 12'h0c9;
  localparam logic [11:0] IDX_133_134 = 12'h0ca;
  localparam logic [11:0] IDX_135_136 = 12'h0cb;
  localparam logic [11:0] IDX_137_138 = 12'h0cc;
  localparam logic [11:0] IDX_139_140 = 12'h0cd;
  localparam logic [11:0] IDX_141_142 = 12'h0ce;
  localparam logic [11:0] IDX_143_144 = 12'h0cf;
  localparam logic [11:0] IDX_145_146 = 12'h0d0;
  localparam logic [11:0] IDX_147_148 = 12'h0d1;
  localparam logic [11:0] IDX_FIRST   = IDX_129_130;
  localparam logic [11:0] IDX_LAST    = IDX_147_148;

  // field positions, upper and lower channel of a pair
  localparam int HI_GLOBAL_EN = 27;
  localparam int HI_LOCAL_RST = 26;
  localparam int HI_MUTE      = 25;
  localparam int HI_SLOT_LSB  = 16;
  localparam int LO_GLOBAL_EN = 11;
  localparam int LO_LOCAL_RST = 10;
  localparam int LO_MUTE      = 9;
  localparam int LO_SLOT_LSB  = 0;
  localparam int SLOT_WIDTH   = 8;

  localparam logic        MUTE_RESET = 1'b1;
  localparam logic [7:0]  SLOT_RESET = 8'h00;
  localparam logic        GEN_RESET  = 1'b0;

  typedef struct packed {
    logic [PAIR_COUNT-1:0]                hiGlobalEn;
    logic [PAIR_COUNT-1:0]                hiMute;
    logic [PAIR_COUNT-1:0][SLOT_WIDTH-1:0] hiSlot;
    logic [PAIR_COUNT-1:0]                loGlobalEn;
    logic [PAIR_COUNT-1:0]                loMute;
    logic [PAIR_COUNT-1:0][SLOT_WIDTH-1:0] loSlot;
    logic [CHAN_COUNT-1:0]                fifoClear;
    logic [31:0]                          rdata;
  } bank_state_t;

endpackage

// ===== hw/channel_pair_control_bank.sv
// apb register bank for channels 129 to 148, two channels per word
// assumes clk at 200 MHz, synchronous sys_rst, same-clock global reset event
// Notes on behaviour
// - each channel has a global fifo reset enable, bit 27 upper and bit 11 lower.
// - each channel has a local fifo reset bit, 26 upper and 10 lower, resetting only it.
// - a self-clearing bit gives one pulse when written 1 and never stays set.
// - each channel has a mute bit, 25 upper and 9 lower, 1 is off, reset value 1.
// - each channel has an 8-bit slot, 23:16 upper and 7:0 lower, reset value 0.
// - bits 31:28, 24, 15:12 and 8 are reserved, read zero and ignore writes.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module channel_pair_control_bank
  import channel_pair_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clkEn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [13:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   globalFifoReset,
  output logic      [CHAN_COUNT-1:0]  fifoClear,
  output logic      [CHAN_COUNT-1:0]  channelMute,
  output logic      [CHAN_COUNT-1:0][SLOT_WIDTH-1:0] channelSlot,
  output logic      [CHAN_COUNT-1:0]  globalFifoResetEnable
);

  bank_state_t state_q;
  bank_state_t state_d;

  logic [11:0] wordIdx;
  logic        inRange;
  logic [3:0]  pairIdx;
  logic        setupRd;
  logic        accessWr;

  assign wordIdx  = paddr[13:2];
  assign inRange  = (wordIdx >= IDX_FIRST) && (wordIdx <= IDX_LAST);
  assign pairIdx  = 4'(wordIdx - IDX_FIRST);
  // answers in the first access cycle; read data captured at setup
  assign setupRd  = psel && !penable && !pwrite;
  assign accessWr = psel && penable && pwrite && inRange;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && (!inRange || (paddr[1:0] != 2'b00));

  always_comb
  begin
    state_d = state_q;
    // pulses last exactly one cycle with clkEn high, and are held while clkEn is low
    state_d.fifoClear = '0;
    for (int p = 0; p < PAIR_COUNT; p++)
    begin
      // external event hits only enabled channels
      state_d.fifoClear[2*p]   = globalFifoReset && state_q.loGlobalEn[p];
      state_d.fifoClear[2*p+1] = globalFifoReset && state_q.hiGlobalEn[p];
    end
    if (accessWr && (paddr[1:0] == 2'b00))
    begin
      for (int p = 0; p < PAIR_COUNT; p++)
      begin
        if (pairIdx == 4'(p))
        begin
          if (pstrb[0])
          begin
            state_d.loSlot[p] = pwdata[LO_SLOT_LSB +: SLOT_WIDTH];
          end
          if (pstrb[1])
          begin
            state_d.loGlobalEn[p] = pwdata[LO_GLOBAL_EN];
            state_d.loMute[p]     = pwdata[LO_MUTE];
            // local reset adds to any global clear in the same cycle
            if (pwdata[LO_LOCAL_RST])
            begin
              state_d.fifoClear[2*p] = 1'b1;
            end
          end
          if (pstrb[2])
          begin
            state_d.hiSlot[p] = pwdata[HI_SLOT_LSB +: SLOT_WIDTH];
          end
          if (pstrb[3])
          begin
            state_d.hiGlobalEn[p] = pwdata[HI_GLOBAL_EN];
            state_d.hiMute[p]     = pwdata[HI_MUTE];
            if (pwdata[HI_LOCAL_RST])
            begin
              state_d.fifoClear[2*p+1] = 1'b1;
            end
          end
        end
      end
    end
    if (setupRd)
    begin
      state_d.rdata = '0;
      if (inRange)
      begin
        for (int p = 0; p < PAIR_COUNT; p++)
        begin
          if (pairIdx == 4'(p))
          begin
            state_d.rdata[HI_GLOBAL_EN] = state_q.hiGlobalEn[p];
            state_d.rdata[HI_MUTE]      = state_q.hiMute[p];
            state_d.rdata[HI_SLOT_LSB +: SLOT_WIDTH] = state_q.hiSlot[p];
            state_d.rdata[LO_GLOBAL_EN] = state_q.loGlobalEn[p];
            state_d.rdata[LO_MUTE]      = state_q.loMute[p];
            state_d.rdata[LO_SLOT_LSB +: SLOT_WIDTH] = state_q.loSlot[p];
            // local reset bits always read zero
            state_d.rdata[HI_LOCAL_RST] = 1'b0;
            state_d.rdata[LO_LOCAL_RST] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q.hiGlobalEn <= {PAIR_COUNT{GEN_RESET}};
      state_q.loGlobalEn <= {PAIR_COUNT{GEN_RESET}};
      state_q.hiMute     <= {PAIR_COUNT{MUTE_RESET}};
      state_q.loMute     <= {PAIR_COUNT{MUTE_RESET}};
      state_q.hiSlot     <= {PAIR_COUNT{SLOT_RESET}};
      state_q.loSlot     <= {PAIR_COUNT{SLOT_RESET}};
      state_q.fifoClear  <= '0;
      state_q.rdata      <= '0;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdata;
  assign fifoClear = state_q.fifoClear;

  always_comb
  begin
    for (int p = 0; p < PAIR_COUNT; p++)
    begin
      channelMute[2*p]             = state_q.loMute[p];
      channelMute[2*p+1]           = state_q.hiMute[p];
      channelSlot[2*p]             = state_q.loSlot[p];
      channelSlot[2*p+1]           = state_q.hiSlot[p];
      globalFifoResetEnable[2*p]   = state_q.loGlobalEn[p];
      globalFifoResetEnable[2*p+1] = state_q.hiGlobalEn[p];
    end
  end

endmodule

// ===== verif/channel_pair_control_bank_sva.sv
// port checks for the channel pair bank
// bound from the bench top; clkEn held high there
`timescale 1ns/1ps
module channel_pair_control_bank_sva
  import channel_pair_pkg::*;
(
  input wire logic                                 clk,
  input wire logic                                 sys_rst,
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic                                 pwrite,
  input wire logic [13:0]                          paddr,
  input wire logic [31:0]                          pwdata,
  input wire logic [3:0]                           pstrb,
  input wire logic [31:0]                          prdata,
  input wire logic                                 globalFifoReset,
  input wire logic [CHAN_COUNT-1:0]                fifoClear,
  input wire logic [CHAN_COUNT-1:0]                channelMute,
  input wire logic [CHAN_COUNT-1:0][SLOT_WIDTH-1:0] channelSlot,
  input wire logic [CHAN_COUNT-1:0]                globalFifoResetEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wr;
  assign wr = psel & penable & pwrite;
  chk_reset_muted: assert property ($past(sys_rst) |-> &channelMute && channelSlot == '0)
    else $error("channels not muted after reset");
  chk_pulse_idle: assert property (!wr && !globalFifoReset |=> fifoClear == '0)
    else $error("fifo clear without cause");
  chk_global_sel: assert property (globalFifoReset && !wr
    |=> fifoClear == $past(globalFifoResetEnable))
    else $error("global clear hit wrong channels");
  chk_local_pulse: assert property (wr && paddr == 14'h320 && pstrb[1] && pwdata[10]
    |=> fifoClear[0])
    else $error("local clear missing");
  chk_enable_write: assert property (wr && paddr == 14'h320 && pstrb[1]
    |=> globalFifoResetEnable[0] == |($past(pwdata) & 32'h800))
    else $error("global enable not written");
  chk_mute_write: assert property (wr && paddr == 14'h320 && pstrb[3]
    |=> channelMute[1] == |($past(pwdata) & 32'h2000000))
    else $error("mute not written");
  chk_slot_write: assert property (wr && paddr == 14'h344 && pstrb[2]
    |=> channelSlot[19] == 8'($past(pwdata) >> 16))
    else $error("slot not written");
  chk_reserved_field_zero: assert property (psel && penable && !pwrite |-> (prdata & 32'hf500f500) == 0)
    else $error("reserved bits read nonzero");
  cover property (wr && pwdata[10]);
  cover property (globalFifoReset);
  cover property (psel && penable && !pwrite && prdata != 0);
endmodule

// ===== verif/channel_pair_control_bank_tb_top.sv
// bench for the channel pair bank over apb
// clkEn held high; global event driven here
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errTotal++; \
  $display("unexpected at %0t got %h exp %h", $time, a, e); end end
module channel_pair_control_bank_tb_top
  import channel_pair_pkg::*;
;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, gRst = 0, pready, pslverr, slvErr;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic [CHAN_COUNT-1:0] fifoClear, channelMute, globalFifoResetEnable;
  logic [CHAN_COUNT-1:0][SLOT_WIDTH-1:0] channelSlot;
  int errTotal = 0, checked = 0, cycles = 0;
  channel_pair_control_bank i_channel_pair_control_bank (.clk(clk), .sys_rst(sys_rst),
    .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .globalFifoReset(gRst), .fifoClear(fifoClear), .channelMute(channelMute),
    .channelSlot(channelSlot), .globalFifoResetEnable(globalFifoResetEnable));
  always #2.5 clk = ~clk;
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    slvErr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic resetValues;
    logic [31:0] r;
    for (int i = 0; i < PAIR_COUNT; i++)
    begin
      xfer(0, 14'(4 * (IDX_FIRST + i)), 0, 4'hf, r);
      `CHK(r, 32'h02000200)
    end
    `CHK(channelSlot, '0)
    `CHK(globalFifoResetEnable, 20'h0)
  endtask
  task automatic localPulse;
    logic [31:0] r;
    xfer(1, 14'h344, 32'hffffffff, 4'hf, r);
    #1 `CHK(fifoClear, 20'hc0000)
    `CHK(channelSlot[19], 8'hff)
    @(posedge clk);
    #1 `CHK(fifoClear, 20'h0)
    xfer(0, 14'h344, 0, 4'hf, r);
    `CHK(r, 32'h0aff0aff)
  endtask
  task automatic globalEvent;
    @(posedge clk) gRst <= 1;
    @(posedge clk) gRst <= 0;
    // only the two enabled channels may clear
    #1 `CHK(fifoClear, 20'hc0000)
  endtask
  task automatic strobeAndBad;
    logic [31:0] r;
    xfer(1, 14'h344, 0, 4'h5, r);
    xfer(0, 14'h344, 0, 4'hf, r);
    `CHK(r, 32'h0a000a00)
    xfer(1, 14'h320, 0, 4'hf, r);
    #1 `CHK(channelMute[1:0], 2'b00)
    // lower channel: enable plus local clear of channel 129 only
    xfer(1, 14'h320, 32'h00000c00, 4'hf, r);
    #1 `CHK(fifoClear, 20'h00001)
    `CHK(globalFifoResetEnable[0], 1'b1)
    xfer(0, 14'h348, 0, 4'hf, r);
    `CHK({slvErr, r}, {1'b1, 32'h0})
  endtask
  task testDone;
    $display("checks %0d errors %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ceiling well above the roughly 60 cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      errTotal++;
      testDone;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    resetValues;
    localPulse;
    globalEvent;
    strobeAndBad;
    testDone;
  end
endmodule
bind channel_pair_control_bank channel_pair_control_bank_sva i_sva (.clk(clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .globalFifoReset(globalFifoReset),
  .fifoClear(fifoClear), .channelMute(channelMute), .channelSlot(channelSlot),
  .globalFifoResetEnable(globalFifoResetEnable));
